// ### rtl/mtom_pkg.sv
// Purpose: Shared types and constants of the motor thermal overload model
// Assumes: Analog quantities are unsigned Q16.16 fixed point, except temperatures in whole deg C
// Notes: Percent values are Q16.16 percent, 100% is 0x0064_0000
package mtom_pkg;

    // Fixed point basics
    localparam int FRAC_BITS = 16;
    localparam logic [31:0] FX_ONE = 32'h0001_0000;
    localparam logic [31:0] PCT_100 = 32'h0064_0000;

    // Standard motor curve coefficients, Q16.16
    localparam logic [31:0] CURVE_NUM = 32'h0002_362F;   // 2.2116623
    localparam logic [31:0] CURVE_SQ = 32'h0000_067A;    // 0.02530337
    localparam logic [31:0] CURVE_LIN = 32'h0000_0CF1;   // 0.05054758
    localparam logic [3:0] SCALE_MIN = 4'h1;
    localparam logic [3:0] SCALE_MAX = 4'hF;             // 15 curves
    // Above this pickup the curve is flat
    localparam logic [31:0] PICKUP_FLAT = 32'h0008_0000;

    // Update tick timing
    localparam int TICK_MS = 100;
    localparam int CLK_KHZ = 200000;
    localparam int TICK_CYCLES_DOC = TICK_MS * CLK_KHZ;
    localparam logic [31:0] TICK_SEC = 32'h0000_1999;    // 0.1 s
    localparam logic [31:0] TICK_PCT_SEC = 32'h000A_0000; // 0.1 s x 100%
    localparam logic [31:0] SEC_PER_MIN = 32'h003C_0000;
    // 5% per minute spread over 600 ticks
    localparam logic [31:0] RISE_PER_TICK = 32'h0000_0222;

    // Divider timing
    localparam logic [5:0] DIV_STEPS = 6'h30;

    typedef enum logic [3:0] {
        S_IDLE, S_RATIO, S_EQ, S_TRIP, S_HEAT,
        S_ALPHA, S_COOL, S_BSEL, S_BDIV
    } mtom_state_e;

    typedef struct packed {
        logic [31:0] ipu;           // Per-unit current, base full load
        logic [31:0] i1_pu;         // Positive sequence, per unit
        logic [31:0] i2_pu;         // Negative sequence, per unit
        logic [15:0] stator_temp;   // Hottest stator sensor, deg C
        logic motor_running;
    } mtom_meas_s;

    typedef struct packed {
        logic [3:0] curve_time_scale;
        logic [7:0] unbal_k;        // Q4.4
        logic [31:0] service_factor;
        logic [31:0] hot_cold;      // Ratio 0..1
        logic [31:0] tau_run_min;
        logic [31:0] tau_stop_min;
        logic stator_temp_feedback_enable;
        logic [15:0] temp_feedback_low_point;
        logic [15:0] temp_feedback_mid_point;
        logic [15:0] temp_feedback_high_point;
    } mtom_cfg_s;

    typedef struct packed {
        mtom_state_e state;
        logic [31:0] tick_cnt;
        logic tick;
        logic div_start;
        logic [31:0] div_a;
        logic [31:0] div_b;
        logic [31:0] ratio;
        logic [31:0] ieq;
        logic [31:0] ttt;
        logic [31:0] alpha;
        logic [31:0] tcu;
        logic trip;
    } mtom_core_s;

    // Saturating Q16.16 multiply
    function automatic logic [31:0] fx_mul(input logic [31:0] a,
                                           input logic [31:0] b);
        logic [63:0] p;
        p = 64'(a) * 64'(b);
        if (p[63:48] != 16'h0000) begin
            return 32'hFFFF_FFFF;
        end
        return p[47:16];
    endfunction

    function automatic logic [31:0] fx_add(input logic [31:0] a,
                                           input logic [31:0] b);
        logic [32:0] s;
        s = 33'(a) + 33'(b);
        return s[32] ? 32'hFFFF_FFFF : s[31:0];
    endfunction

    function automatic logic [31:0] fx_max(input logic [31:0] a,
                                           input logic [31:0] b);
        return (a > b) ? a : b;
    endfunction

    // Square root of a Q16.16 value, result Q16.16
    function automatic logic [31:0] fx_sqrt(input logic [31:0] v);
        logic [47:0] x;
        logic [23:0] root;
        logic [23:0] cand;
        x = {v, 16'h0000};
        root = 24'h00_0000;
        cand = 24'h00_0000;
        for (int i = 23; i >= 0; i--) begin
            cand = root | (24'h00_0001 << i);
            if ((48'(cand) * 48'(cand)) <= x) begin
                root = cand;
            end
        end
        return {8'h00, root};
    endfunction

    // Launch a divide and move to its wait state
    function automatic mtom_core_s div_go(input mtom_core_s s,
                                          input logic [31:0] a,
                                          input logic [31:0] b,
                                          input mtom_state_e nx);
        mtom_core_s o;
        o = s;
        o.div_a = a;
        o.div_b = b;
        o.div_start = 1'b1;
        o.state = nx;
        return o;
    endfunction

endpackage

// ### rtl/mtom_divider.sv
// Purpose: Serial Q16.16 divider, q = a / b
// Assumes: start is ignored while busy
// Notes: Divide by zero and overflow return all ones
`timescale 1ns/1ps
`default_nettype none
module mtom_divider
    import mtom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    output logic done,
    output logic [31:0] q
);
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [32:0] rem;
        logic [47:0] dvd;
        logic [47:0] quo;
        logic [31:0] b;
        logic done;
        logic [31:0] q;
    } mtom_div_s;

    mtom_div_s r;
    mtom_div_s next_r;

    // One quotient bit per cycle keeps the area small; 48 cycles a divide
    always_comb begin
        logic [32:0] shifted;
        shifted = 33'h0_0000_0000;
        next_r = r;
        next_r.done = 1'b0;
        if (!r.busy) begin
            if (start) begin
                next_r.busy = 1'b1;
                next_r.cnt = DIV_STEPS;
                next_r.rem = '0;
                next_r.dvd = {a, 16'h0000};
                next_r.quo = '0;
                next_r.b = b;
            end
        end else begin
            shifted = {r.rem[31:0], r.dvd[47]};
            next_r.dvd = {r.dvd[46:0], 1'b0};
            if (shifted >= {1'b0, r.b}) begin
                next_r.rem = shifted - {1'b0, r.b};
                next_r.quo = {r.quo[46:0], 1'b1};
            end else begin
                next_r.rem = shifted;
                next_r.quo = {r.quo[46:0], 1'b0};
            end
            next_r.cnt = r.cnt - 6'h01;
            if (r.cnt == 6'h01) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.q = (next_r.quo[47:32] != 16'h0000) ?
                           32'hFFFF_FFFF : next_r.quo[31:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
    assign q = r.q;

    a_div_finishes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !r.busy) |-> ##49 done)
        else $error("divider did not finish in 49 cycles");
endmodule
`default_nettype wire

// ### rtl/mtom_core.sv
// Purpose: Motor thermal overload model with trip decision
// Assumes: Measurement and setting inputs are steady across one update
// Notes: One update per tick; a tick arriving mid-update is skipped
//
// Summary of operation
// - Curve time scale 1..15 shifts the standard curve only along time.
// - Trip time is scale x 2.2116623 over quadratic in pickup minus one.
// - At the curve break the longer trip time is used.
// - Heating current is root of I squared times one plus k ratio squared.
// - With k zero, heating current is the positive sequence current.
// - Below service level capacity decays, running or stopped time constant.
// - Below service level capacity settles to Ieq times (1-hot/cold) x 100.
// - Toward settle level capacity rises 5%/min or falls exponentially.
// - One enable switches the stator temperature bias on or off.
// - Below the low point no temperature bias is applied.
// - Above the high point the bias value is forced to 100%.
// - In between, capacity becomes the higher of model and bias value.
// - Bias value at mid point is (1-hot/cold) x 100%.
// - Bias interpolates from the segment's lower point toward 100%.
// - Trip asserts only when model capacity exceeds 100%.
// - Above service level, each 100 ms capacity grows by 100 ms over trip time, in percent.
//
`timescale 1ns/1ps
`default_nettype none
module mtom_core
    import mtom_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DOC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire mtom_meas_s meas,
    input wire mtom_cfg_s cfg,
    output logic [31:0] tcu_pct,
    output logic [31:0] ieq_pu,
    output logic trip
);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    mtom_core_s r;
    mtom_core_s next_r;
    logic div_done;
    logic [31:0] div_q;

    mtom_divider u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(r.div_start),
        .a(r.div_a),
        .b(r.div_b),
        .done(div_done),
        .q(div_q)
    );

    // Update sequencer; all settings are sampled in the state that uses them
    always_comb begin
        logic [31:0] kq;
        logic [31:0] ieq2;
        logic [31:0] pick;
        logic [31:0] p1;
        logic [31:0] den;
        logic [31:0] num;
        logic [31:0] cold;
        logic [31:0] settle;
        logic [31:0] center;
        logic [31:0] tmp;
        logic [31:0] t_lo;
        logic [31:0] t_mid;
        logic [31:0] t_hi;
        logic [31:0] bias;
        logic [3:0] scl;
        kq = {12'h000, cfg.unbal_k, 12'h000};
        ieq2 = '0;
        pick = '0;
        p1 = '0;
        den = '0;
        num = '0;
        cold = FX_ONE - cfg.hot_cold;
        settle = fx_mul(fx_mul(r.ieq, cold), PCT_100);
        center = fx_mul(cold, PCT_100);
        tmp = {meas.stator_temp, 16'h0000};
        t_lo = {cfg.temp_feedback_low_point, 16'h0000};
        t_mid = {cfg.temp_feedback_mid_point, 16'h0000};
        t_hi = {cfg.temp_feedback_high_point, 16'h0000};
        bias = '0;
        scl = cfg.curve_time_scale;
        next_r = r;
        next_r.div_start = 1'b0;

        // Free running update tick
        if (r.tick_cnt >= TICK_LAST) begin
            next_r.tick_cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
            next_r.tick = 1'b0;
        end

        unique case (r.state)
            S_IDLE: begin
                if (r.tick) begin
                    if (cfg.unbal_k != 8'h00 && meas.i1_pu != '0) begin
                        next_r = div_go(next_r, meas.i2_pu, meas.i1_pu,
                                        S_RATIO);
                    end else begin
                        next_r.ratio = '0;
                        next_r.state = S_EQ;
                    end
                end
            end
            S_RATIO: begin
                if (div_done) begin
                    next_r.ratio = div_q;
                    next_r.state = S_EQ;
                end
            end
            S_EQ: begin
                if (cfg.unbal_k == 8'h00) begin
                    next_r.ieq = meas.i1_pu;
                end else begin
                    ieq2 = fx_mul(fx_mul(meas.ipu, meas.ipu),
                        fx_add(FX_ONE, fx_mul(kq,
                        fx_mul(r.ratio, r.ratio))));
                    next_r.ieq = fx_sqrt(ieq2);
                end
                if (next_r.ieq > cfg.service_factor) begin
                    // Flat tail beyond the break keeps the longer time
                    pick = (next_r.ieq > PICKUP_FLAT) ?
                           PICKUP_FLAT : next_r.ieq;
                    p1 = (pick > FX_ONE) ? pick - FX_ONE : '0;
                    den = fx_add(fx_mul(CURVE_SQ, fx_mul(p1, p1)),
                                 fx_mul(CURVE_LIN, p1));
                    if (scl < SCALE_MIN) begin
                        scl = SCALE_MIN;
                    end else if (scl > SCALE_MAX) begin
                        scl = SCALE_MAX;
                    end
                    num = fx_mul({12'h000, scl, 16'h0000}, CURVE_NUM);
                    next_r = div_go(next_r, num, den, S_TRIP);
                end else begin
                    // Decay factor derived once per tick from the constant
                    next_r = div_go(next_r, TICK_SEC, fx_mul(
                        meas.motor_running ? cfg.tau_run_min :
                        cfg.tau_stop_min, SEC_PER_MIN), S_ALPHA);
                end
            end
            S_TRIP: begin
                if (div_done) begin
                    next_r.ttt = div_q;
                    next_r = div_go(next_r, TICK_PCT_SEC, div_q, S_HEAT);
                end
            end
            S_HEAT: begin
                if (div_done) begin
                    next_r.tcu = fx_add(r.tcu, div_q);
                    next_r.state = S_BSEL;
                end
            end
            S_ALPHA: begin
                if (div_done) begin
                    next_r.alpha = div_q;
                    next_r.state = S_COOL;
                end
            end
            S_COOL: begin
                if (r.tcu < settle) begin
                    // Fixed rise, never overshooting the settle level
                    next_r.tcu = fx_add(r.tcu, RISE_PER_TICK);
                    if (next_r.tcu > settle) begin
                        next_r.tcu = settle;
                    end
                end else begin
                    next_r.tcu = r.tcu - fx_mul(r.tcu - settle,
                                                r.alpha);
                end
                next_r.state = S_BSEL;
            end
            S_BSEL: begin
                next_r.state = S_IDLE;
                if (cfg.stator_temp_feedback_enable) begin
                    if (tmp > t_hi) begin
                        next_r.tcu = fx_max(r.tcu, PCT_100);
                    end else if (tmp >= t_lo) begin
                        if (tmp < t_mid) begin
                            next_r = div_go(next_r, tmp - t_lo,
                                            t_mid - t_lo, S_BDIV);
                        end else begin
                            next_r = div_go(next_r, tmp - t_mid,
                                            t_hi - t_mid, S_BDIV);
                        end
                    end
                end
            end
            S_BDIV: begin
                if (div_done) begin
                    bias = fx_add(fx_mul(div_q, PCT_100 - center),
                                  center);
                    next_r.tcu = fx_max(r.tcu, bias);
                    next_r.state = S_IDLE;
                end
            end
            default: begin
                next_r.state = S_IDLE;
            end
        endcase

        // Bias can only reach 100%, never above, so it cannot trip alone
        next_r.trip = next_r.tcu > PCT_100;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tcu_pct = r.tcu;
    assign ieq_pu = r.ieq;
    assign trip = r.trip;

    // Settle level rebuilt apart from the sequencer for the checks below
    logic [31:0] settle_chk;
    assign settle_chk = fx_mul(fx_mul(r.ieq, FX_ONE - cfg.hot_cold),
                               PCT_100);

    a_trip_needs_tcu: assert property (@(posedge clk_sys)
        disable iff (!rst_n) trip |-> (tcu_pct > PCT_100))
        else $error("trip without capacity above 100 percent");
    a_k_zero_ieq: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (r.state == S_EQ && cfg.unbal_k == 8'h00) |=>
        (ieq_pu == $past(meas.i1_pu)))
        else $error("k zero did not use positive sequence current");
    a_heat_grows: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (r.state == S_HEAT && div_done) |=>
        (tcu_pct >= $past(tcu_pct)) && (r.state == S_BSEL))
        else $error("heating step lowered capacity");
    a_rise_limit: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (r.state == S_COOL && r.tcu < settle_chk) |=>
        (tcu_pct - $past(tcu_pct) <= RISE_PER_TICK))
        else $error("capacity rose faster than 5 percent per minute");
    a_cool_falls: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (r.state == S_COOL && r.tcu >= settle_chk) |=>
        (tcu_pct <= $past(tcu_pct)))
        else $error("cooling step raised capacity");
    a_bias_off: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (r.state == S_BSEL && (!cfg.stator_temp_feedback_enable ||
        meas.stator_temp < cfg.temp_feedback_low_point)) |=>
        (tcu_pct == $past(tcu_pct)) && (r.state == S_IDLE))
        else $error("bias applied while disabled or cold");
    a_bias_force: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (r.state == S_BSEL && cfg.stator_temp_feedback_enable &&
        meas.stator_temp > cfg.temp_feedback_high_point) |=>
        (tcu_pct >= PCT_100))
        else $error("hot stator did not force full bias");
    a_bias_keeps_max: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (r.state == S_BDIV && div_done) |=>
        (tcu_pct >= $past(tcu_pct)) && (r.state == S_IDLE))
        else $error("bias lowered capacity");
    a_update_bounded: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (r.state == S_IDLE && r.tick) |=> ##[1:220] (r.state == S_IDLE))
        else $error("update did not complete in time");
endmodule
`default_nettype wire

// ### bench/mtom_fe_model.sv
// Purpose: Measurement front end stand-in feeding the thermal model
// Assumes: Readings are loaded well clear of an update tick
// Notes: Holds each set of readings until the next load
`timescale 1ns/1ps
`default_nettype none
module mtom_fe_model
    import mtom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire mtom_meas_s next_meas,
    output var mtom_meas_s meas
);
    // Core reads inputs late in an update, so they only move on a load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meas <= '0;
        end else if (load) begin
            meas <= next_meas;
        end
    end
endmodule
`default_nettype wire

// ### bench/mtom_tb.sv
// Purpose: Self-checking bench of the thermal overload core
// Assumes: Short tick period; one real-valued model checked per update
// Notes: Fixed point results are accepted within a small tolerance
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 64'(e), 64'(g), ((e) === (g)))
module testbench;
    import mtom_pkg::*;
    localparam int T = 400;
    localparam int SAMP = 260;
    localparam int LIMIT = 40000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic fe_load = 1'b0;
    mtom_meas_s fe_next = '0;
    mtom_meas_s meas;
    mtom_cfg_s cfg = '0;
    logic [31:0] tcu_pct;
    logic [31:0] ieq_pu;
    logic trip;
    logic [31:0] p;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int total = 0;
    real m_tcu = 0.0;
    real m_ieq = 0.0;

    always #2.5 clk_sys = ~clk_sys;

    // Edges since release line samples up with the update tick
    always @(posedge clk_sys) begin
        total++;
        cyc = rst_n ? cyc + 1 : 0;
        if (total == LIMIT) begin
            fail_count++;
            complete_run();
        end
    end

    mtom_fe_model i_fe (.clk_sys(clk_sys), .rst_n(rst_n), .load(fe_load),
        .next_meas(fe_next), .meas(meas));
    mtom_core #(.TICK_CYCLES(T)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .meas(meas), .cfg(cfg), .tcu_pct(tcu_pct), .ieq_pu(ieq_pu),
        .trip(trip));

    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [63:0] e,
                             input logic [63:0] g, input logic ok);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic real fx(input logic [31:0] v);
        return real'(v) / 65536.0;
    endfunction

    function automatic logic [31:0] tofx(input real r);
        return 32'($rtoi(r * 65536.0));
    endfunction

    // Rounding differs from real maths, so a close value counts as exact
    function automatic logic [31:0] snap(input real e, input logic [31:0] g);
        real d;
        if ($isunknown(g)) return g;
        d = fx(g) - e;
        if (d < 0.0) d = -d;
        return (d <= 0.002 * e + 0.001) ? tofx(e) : g;
    endfunction

    function automatic mtom_meas_s mk(input logic [31:0] ip, i1, i2,
                                      input logic [15:0] t, input logic run);
        mtom_meas_s m;
        m.ipu = ip;
        m.i1_pu = i1;
        m.i2_pu = i2;
        m.stator_temp = t;
        m.motor_running = run;
        return m;
    endfunction

    // One update of the thermal model in real arithmetic
    task automatic model_update();
        real k, ip, i1, i2, x, ttt, st, tau, c, b, t, lo, mi, hi;
        k = real'(cfg.unbal_k) / 16.0;
        ip = fx(meas.ipu);
        i1 = fx(meas.i1_pu);
        i2 = fx(meas.i2_pu);
        m_ieq = (k == 0.0) ? i1 : $sqrt(ip * ip * (1.0 + k * (i2 / i1)
            * (i2 / i1)));
        if (m_ieq > fx(cfg.service_factor)) begin
            x = (m_ieq > 8.0) ? 7.0 : m_ieq - 1.0;
            ttt = cfg.curve_time_scale * 2.2116623
                / (0.02530337 * x * x + 0.05054758 * x);
            m_tcu += 10.0 / ttt;
        end else begin
            st = m_ieq * (1.0 - fx(cfg.hot_cold)) * 100.0;
            tau = fx(meas.motor_running ? cfg.tau_run_min : cfg.tau_stop_min);
            if (m_tcu < st) begin
                m_tcu = (m_tcu + 5.0 / 600.0 > st) ? st
                    : m_tcu + 5.0 / 600.0;
            end else begin
                m_tcu -= (m_tcu - st) * 0.1 / (tau * 60.0);
            end
        end
        if (cfg.stator_temp_feedback_enable) begin
            t = cfg.temp_feedback_low_point;
            lo = t;
            mi = cfg.temp_feedback_mid_point;
            hi = cfg.temp_feedback_high_point;
            t = meas.stator_temp;
            c = (1.0 - fx(cfg.hot_cold)) * 100.0;
            if (t > hi) b = 100.0;
            else if (t > mi) b = (t - mi) / (hi - mi) * (100.0 - c) + c;
            else if (t >= lo) b = (t - lo) / (mi - lo) * (100.0 - c) + c;
            else b = 0.0;
            if (b > m_tcu) m_tcu = b;
        end
    endtask

    task automatic apply(input mtom_meas_s m);
        fe_next = m;
        fe_load = 1'b1;
        @(posedge clk_sys);
        #1;
        fe_load = 1'b0;
    endtask

    // Wait for each settled update and compare it with the model
    task automatic step(input int n);
        repeat (n) begin
            do begin
                @(posedge clk_sys);
                #1;
            end while (!(cyc > T && cyc % T == SAMP));
            model_update();
            `CHK("ieq_pu", tofx(m_ieq), snap(m_ieq, ieq_pu));
            `CHK("tcu_pct", tofx(m_tcu), snap(m_tcu, tcu_pct));
            if (m_tcu > 100.5 || m_tcu < 99.5) begin
                `CHK("trip", m_tcu > 100.0, trip);
            end
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        m_tcu = 0.0;
        m_ieq = 0.0;
        `CHK("tcu_rst", 32'h0000_0000, tcu_pct);
        `CHK("trip_rst", 1'b0, trip);
    endtask

    initial begin
        void'($urandom(31));
        cfg.curve_time_scale = 4'h1;
        cfg.service_factor = FX_ONE;
        cfg.hot_cold = 32'h0000_8000;
        cfg.tau_run_min = 32'h0000_0CCC;
        cfg.tau_stop_min = 32'h0000_3333;
        cfg.temp_feedback_low_point = 16'h0028;
        cfg.temp_feedback_mid_point = 16'h0050;
        cfg.temp_feedback_high_point = 16'h0082;
        do_reset();
        // Every curve scale at a random pickup, per-unit current ignored
        for (int s = 1; s <= 15; s++) begin
            cfg.curve_time_scale = 4'(s);
            p = 32'h0001_8000 + ($urandom % 32'h0005_0000);
            apply(mk(p + 32'h0000_2000, p, 32'h0000_4000, 16'h0014, 1'b1));
            step(1);
            `CHK("ieq_k0", meas.i1_pu, ieq_pu);
        end
        // Past the curve break the trip time stays at its longer value
        cfg.curve_time_scale = 4'h3;
        for (int i = 0; i < 3; i++) begin
            p = 32'h0008_0000 + 32'(i) * 32'h0002_0000;
            apply(mk(p, p, 32'h0000_0000, 16'h0014, 1'b1));
            step(1);
        end
        // Unbalance bias with random weights, per-unit and negative sequence currents
        repeat (4) begin
            cfg.unbal_k = 8'h10 + 8'($urandom % 32'h70);
            p = 32'h0001_4000 + ($urandom % 32'h0001_0000);
            apply(mk(p, 32'h0001_4000, $urandom % 32'h0000_6000,
                16'h0014, 1'b1));
            step(1);
        end
        // Light load cools, running then stopped
        cfg.unbal_k = 8'h00;
        cfg.hot_cold = 32'h0000_E666;
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0, 16'h0014, 1'b1));
        step(4);
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0, 16'h0014, 1'b0));
        step(4);
        // Reset mid-run, then a slow rise toward the settle level
        do_reset();
        cfg.hot_cold = 32'h0000_8000;
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0, 16'h001E, 1'b1));
        step(3);
        // Stator temperature feedback through every segment
        cfg.stator_temp_feedback_enable = 1'b1;
        step(2);
        cfg.stator_temp_feedback_enable = 1'b0;
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0, 16'h0096, 1'b1));
        step(2);
        cfg.stator_temp_feedback_enable = 1'b1;
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0,
            16'h0029 + 16'($urandom % 32'h26), 1'b1));
        step(2);
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0,
            16'h0051 + 16'($urandom % 32'h30), 1'b1));
        step(2);
        apply(mk(32'h0000_8000, 32'h0000_8000, 32'h0, 16'h0096, 1'b1));
        step(2);
        `CHK("tcu_full", PCT_100, tcu_pct);
        `CHK("trip_bias", 1'b0, trip);
        // Heavy overload on top of full bias must trip
        apply(mk(32'h0008_0000, 32'h0008_0000, 32'h0, 16'h0096, 1'b1));
        step(4);
        `CHK("trip_load", 1'b1, trip);
        complete_run();
    end
endmodule
`default_nettype wire
